// >>> include/lacid_cfg_if.sv
`timescale 1ns/1ns
// Link between the register front end and the source-setting chain
interface lacid_cfg_if;
  import lacid_pkg::*;
  logic refresh; // One-cycle refresh command
  lacid_byte_t programmed; // Programmed, not yet active settings
  logic wr_latched; // Software write to latched copy
  lacid_byte_t wr_data; // Data for that write
  lacid_byte_t active; // Settings now in force
  lacid_byte_t latched; // Settings in force before last refresh

  modport ctrl (
    output refresh,
    output programmed,
    output wr_latched,
    output wr_data,
    input active,
    input latched
  );

  modport chain (
    input refresh,
    input programmed,
    input wr_latched,
    input wr_data,
    output active,
    output latched
  );
endinterface

// >>> include/lacid_pkg.sv
// Shared constants for the latched accumulator-source and ID register group
package lacid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and channel layout
  localparam int LACID_ADDR_W = 8; // Register address width
  localparam int LACID_DATA_W = 8; // Register data width
  localparam int LACID_NUM_CH = 4; // Measurement channels
  localparam int LACID_SRC_W = 2; // Source field width per channel
  // Channel 1 sits in the top field, later channels step down
  localparam int LACID_CH1_LSB = 6;

  typedef logic [LACID_ADDR_W-1:0] lacid_addr_t;
  typedef logic [LACID_DATA_W-1:0] lacid_byte_t;

  // Accumulator source codes, declared order gives 00, 01, 10
  typedef enum logic [LACID_SRC_W-1:0] {
    LACID_SRC_POWER,
    LACID_SRC_SENSE,
    LACID_SRC_VBUS
  } lacid_src_e;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam lacid_addr_t LACID_OFF_LATCHED = 8'h4b; // Latched sources
  localparam lacid_addr_t LACID_OFF_STATUS = 8'h80; // Dataset status
  localparam lacid_addr_t LACID_OFF_PART = 8'hfd; // Part code
  localparam lacid_addr_t LACID_OFF_MAKER = 8'hfe; // Maker code
  localparam lacid_addr_t LACID_OFF_REV = 8'hff; // Die revision

  // Values after reset
  localparam lacid_byte_t LACID_LATCHED_RST = 8'h00;
  localparam lacid_byte_t LACID_ACTIVE_RST = 8'h00;
  localparam lacid_byte_t LACID_RDATA_RST = 8'h00;

  // Status register fields
  localparam int LACID_STAT_VALID_BIT = 0; // Latched dataset valid
  localparam int LACID_STAT_BUSY_BIT = 1; // Settle timer running

  ////////////////////////////////////////////////////////////////////////////
  // Timing: result set settles this long after a refresh
  localparam int LACID_SETTLE_MS = 1;
  localparam int LACID_CLK_MHZ = 125;
  localparam int LACID_SETTLE_CYCLES = LACID_SETTLE_MS * 1000 * LACID_CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Lowest bit of a channel's source field, channel index from zero
  function automatic int lacid_ch_lsb(input int ch);
    lacid_ch_lsb = LACID_CH1_LSB - ch * LACID_SRC_W;
  endfunction

  // Reserved source code 11 is forced to zero in every field
  function automatic lacid_byte_t lacid_clean_cfg(input lacid_byte_t raw);
    lacid_byte_t res;
    res = raw;
    for (int ch = 0; ch < LACID_NUM_CH; ch++)
    begin
      if (raw[lacid_ch_lsb(ch) +: LACID_SRC_W] == 2'h3)
      begin
        res[lacid_ch_lsb(ch) +: LACID_SRC_W] = 2'h0;
      end
    end
    return res;
  endfunction

endpackage

// >>> src/lacid_cfg_chain.sv
`timescale 1ns/1ns
// Per-channel active and latched accumulator source fields
module lacid_cfg_chain
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Front end link
  lacid_cfg_if.chain cfg
);
  import lacid_pkg::*;

  // Cleaned inputs, reserved codes never reach the fields
  lacid_byte_t prog_clean;
  lacid_byte_t wr_clean;

  assign prog_clean = lacid_clean_cfg(cfg.programmed);
  assign wr_clean = lacid_clean_cfg(cfg.wr_data);

  ////////////////////////////////////////////////////////////////////////////
  // One pair of fields per channel
  genvar ch;
  generate
    for (ch = 0; ch < LACID_NUM_CH; ch++)
    begin : g_ch
      localparam int LSB = lacid_ch_lsb(ch);
      logic [LACID_SRC_W-1:0] act_r; // Field now in force
      logic [LACID_SRC_W-1:0] lat_r; // Field before last refresh

      // Refresh shifts active into latched, programmed into active
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          act_r <= LACID_ACTIVE_RST[LSB +: LACID_SRC_W];
          lat_r <= LACID_LATCHED_RST[LSB +: LACID_SRC_W];
        end
        else if (ce)
        begin
          if (cfg.refresh)
          begin
            // Refresh beats a software write in the same cycle
            lat_r <= act_r;
            act_r <= prog_clean[LSB +: LACID_SRC_W];
          end
          else if (cfg.wr_latched)
          begin
            lat_r <= wr_clean[LSB +: LACID_SRC_W];
          end
        end
      end

      // Field placement, channel 1 in the top bits
      assign cfg.active[LSB +: LACID_SRC_W] = act_r;
      assign cfg.latched[LSB +: LACID_SRC_W] = lat_r;
    end
  endgenerate

endmodule

// >>> src/lacid_regs.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
// Notes on behaviour
// - Latched copy holds settings before last refresh.
// - Refresh: active to latched, programmed to active.
// - Latched copy describes the current result dataset.
// - Latched copy valid 1 ms after refresh.
// - Channel fields: ch1 7-6 down to ch4 1-0.
// - Codes: power, sense, bus; 11 reads zero.
// - Read-only eight-bit part code register.
// - Read-only eight-bit maker code register.
// - Read-only eight-bit die revision register.
module lacid_regs
#(
  // Settle time in cycles, shorten for simulation
  parameter int SETTLE_CYCLES = lacid_pkg::LACID_SETTLE_CYCLES,
  // Identification values, arbitrary neutral defaults
  parameter lacid_pkg::lacid_byte_t PART_CODE = 8'h5a,
  parameter lacid_pkg::lacid_byte_t MAKER_CODE = 8'h3c,
  parameter lacid_pkg::lacid_byte_t DIE_REV_CODE = 8'h01
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire lacid_pkg::lacid_addr_t reg_addr,
  input wire lacid_pkg::lacid_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lacid_pkg::lacid_byte_t reg_rdata,
  // Configuration side
  input wire lacid_pkg::lacid_byte_t prog_cfg,
  input wire logic refresh_cmd,
  output lacid_pkg::lacid_byte_t active_cfg,
  output logic latched_valid
);
  import lacid_pkg::*;

  // Counter sized to hold the full settle count
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // True when the address hits a write-accepting register
  function automatic logic lacid_is_writable(input lacid_addr_t a);
    lacid_is_writable = (a == LACID_OFF_LATCHED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Internal state
  lacid_cfg_if cfg_link (); // Link to the field chain
  logic [CNT_W-1:0] settle_cnt_r; // Cycles left until results settle
  logic valid_r; // Latched copy matches the settled dataset
  lacid_byte_t rdata_r; // Read data, one cycle after strobe
  lacid_byte_t rdata_nxt; // Read mux output
  lacid_byte_t status_word; // Status register image
  logic wr_hit; // Write lands on the latched copy

  ////////////////////////////////////////////////////////////////////////////
  // Drive the chain
  // Only the latched copy accepts writes; ID and status drop them
  assign wr_hit = reg_wr & lacid_is_writable(reg_addr);
  assign cfg_link.refresh = refresh_cmd;
  assign cfg_link.programmed = prog_cfg;
  assign cfg_link.wr_latched = wr_hit;
  assign cfg_link.wr_data = reg_wdata;

  // Active and latched source fields
  lacid_cfg_chain u_chain
  (
    .clk_sys (clk_sys),
    .srst (srst),
    .ce (ce),
    .cfg (cfg_link.chain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settle timer: the latched copy pairs with the result set, so both
  // become trustworthy only once the results have settled
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      settle_cnt_r <= CNT_ZERO;
    end
    else if (ce)
    begin
      if (refresh_cmd)
      begin
        // A new refresh restarts the wait
        settle_cnt_r <= CNT_LOAD;
      end
      else if (settle_cnt_r != CNT_ZERO)
      begin
        settle_cnt_r <= settle_cnt_r - CNT_ONE;
      end
    end
  end

  // Valid flag: cleared by refresh, set when the wait runs out
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      // No dataset exists before the first refresh
      valid_r <= 1'b0;
    end
    else if (ce)
    begin
      if (refresh_cmd)
      begin
        valid_r <= 1'b0;
      end
      else if (settle_cnt_r == CNT_ONE)
      begin
        valid_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status image
  always_comb
  begin
    status_word = '0;
    status_word[LACID_STAT_VALID_BIT] = valid_r;
    status_word[LACID_STAT_BUSY_BIT] = (settle_cnt_r != CNT_ZERO);
  end

  // Read mux, unmapped addresses read zero
  always_comb
  begin
    case (reg_addr)
      LACID_OFF_LATCHED: rdata_nxt = cfg_link.latched;
      LACID_OFF_STATUS: rdata_nxt = status_word;
      LACID_OFF_PART: rdata_nxt = PART_CODE;
      LACID_OFF_MAKER: rdata_nxt = MAKER_CODE;
      LACID_OFF_REV: rdata_nxt = DIE_REV_CODE;
      default: rdata_nxt = LACID_RDATA_RST;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdata_r <= LACID_RDATA_RST;
    end
    else if (ce)
    begin
      if (reg_rd)
      begin
        rdata_r <= rdata_nxt;
      end
      else
      begin
        rdata_r <= LACID_RDATA_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each from a flip-flop
  assign reg_rdata = rdata_r;
  assign active_cfg = cfg_link.active;
  assign latched_valid = valid_r;

endmodule

// >>> testbench/lacid_regs_props.sv
`timescale 1ns/1ns
// Port-level checks of the latched source and ID register group
module lacid_regs_props
#(
  parameter int SETTLE_CYCLES = 20,
  parameter lacid_pkg::lacid_byte_t PART_CODE = 8'h00,
  parameter lacid_pkg::lacid_byte_t MAKER_CODE = 8'h00,
  parameter lacid_pkg::lacid_byte_t DIE_REV_CODE = 8'h00
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire lacid_pkg::lacid_addr_t reg_addr,
  input wire lacid_pkg::lacid_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire lacid_pkg::lacid_byte_t reg_rdata,
  // Configuration side
  input wire lacid_pkg::lacid_byte_t prog_cfg,
  input wire logic refresh_cmd,
  input wire lacid_pkg::lacid_byte_t active_cfg,
  input wire logic latched_valid
);
  import lacid_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // No field holds the reserved code
  function automatic logic ok(input lacid_byte_t b);
    return !(&b[7:6] | &b[5:4] | &b[3:2] | &b[1:0]);
  endfunction
  wire go = ce && refresh_cmd; // Refresh taken
  wire rd_lat = ce && reg_rd && reg_addr == LACID_OFF_LATCHED; // Latched read
  int cnt_r; // Cycles since refresh; saturates so it never wraps
  // Settle counter
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cnt_r <= 0;
    else if (go)
      cnt_r <= 1;
    else if (ce && cnt_r != 0 && cnt_r <= SETTLE_CYCLES)
      cnt_r <= cnt_r + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_part;
    ce && reg_rd && reg_addr == LACID_OFF_PART |=> reg_rdata == PART_CODE;
  endproperty
  a_part: assert property (p_part) else $error("bad part code");
  property p_maker;
    ce && reg_rd && reg_addr == LACID_OFF_MAKER |=> reg_rdata == MAKER_CODE;
  endproperty
  a_maker: assert property (p_maker) else $error("bad maker code");
  property p_rev;
    ce && reg_rd && reg_addr == LACID_OFF_REV |=> reg_rdata == DIE_REV_CODE;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision code");
  property p_lat;
    go ##1 (rd_lat && !refresh_cmd) |=> reg_rdata == $past(active_cfg, 2);
  endproperty
  a_lat: assert property (p_lat) else $error("latched not old active");
  property p_act;
    go && ok(prog_cfg) |=> active_cfg == $past(prog_cfg);
  endproperty
  a_act: assert property (p_act) else $error("active not programmed");
  property p_res;
    ok(active_cfg);
  endproperty
  a_res: assert property (p_res) else $error("reserved code active");
  // Valid exactly once a full settle time has passed since the refresh
  property p_settle;
    latched_valid == (cnt_r > SETTLE_CYCLES);
  endproperty
  a_settle: assert property (p_settle) else $error("valid timing");
  property p_wr;
    ce && reg_wr && reg_addr == LACID_OFF_LATCHED && !refresh_cmd
      && ok(reg_wdata) ##1 (rd_lat && !refresh_cmd)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("field layout");
  // Enable low freezes the settings in force and the valid flag
  property p_hold;
    !ce |=> $stable(active_cfg) && $stable(latched_valid);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved, enable low");
endmodule

bind lacid_regs lacid_regs_props #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .PART_CODE(PART_CODE), .MAKER_CODE(MAKER_CODE),
  .DIE_REV_CODE(DIE_REV_CODE)) u_props (.*);

// >>> testbench/tb_latched_accum_config_and_id_regs.sv
`timescale 1ns/1ns
// Self-checking bench for the latched source and ID registers
module tb_latched_accum_config_and_id_regs;
  import lacid_pkg::*;
  localparam int SC = 20; // Short settle time keeps the run brief
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1; // Clock enable, dropped in one scenario
  lacid_addr_t reg_addr = 8'h00;
  lacid_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  lacid_byte_t prog_cfg = 8'h00;
  logic refresh_cmd = 1'b0;
  lacid_byte_t reg_rdata, active_cfg;
  logic latched_valid;
  logic rd_d = 1'b0; // Read taken last cycle
  lacid_byte_t exp_q[$]; // Expected read data, oldest first
  int n_errors = 0;
  int check_count = 0;
  int seed = 29426;
  lacid_byte_t act_m = LACID_ACTIVE_RST; // Model of settings in force
  lacid_byte_t lat_m, p;
  // ID places plus one unmapped address; codes are arbitrary
  lacid_addr_t ids[4] = '{LACID_OFF_PART, LACID_OFF_MAKER, LACID_OFF_REV,
    8'h10};
  lacid_byte_t codes[4] = '{8'ha7, 8'h3c, 8'h01, 8'h00};

  lacid_regs #(.SETTLE_CYCLES(SC), .PART_CODE(8'ha7), .MAKER_CODE(8'h3c),
    .DIE_REV_CODE(8'h01)) DUT (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_cfg(prog_cfg),
    .refresh_cmd(refresh_cmd), .active_cfg(active_cfg),
    .latched_valid(latched_valid));

  ////////////////////////////////////////////////////////////////////////////
  always #4 clk_sys = ~clk_sys;
  // Reserved code cleared field by field
  function automatic lacid_byte_t cln(input lacid_byte_t b);
    for (int k = 0; k < 8; k += 2)
      if (b[k+:2] == 2'h3)
        b[k+:2] = 2'h0;
    return b;
  endfunction
  task automatic chk(input lacid_byte_t a, input lacid_byte_t e);
    check_count++;
    if (a !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  // One bus cycle; every strobe set once so none is assigned twice
  task automatic op(input logic w, r, f, input lacid_addr_t a,
    input lacid_byte_t wd, e);
    reg_wr <= w;
    reg_rd <= r;
    refresh_cmd <= f;
    reg_addr <= a;
    reg_wdata <= wd;
    if (r)
      exp_q.push_back(e);
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    repeat (n) op(0, 0, 0, 8'h00, 8'h00, 8'h00);
  endtask
  task automatic end_sim;
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Read data stands one cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  // Hang guard
  initial
  begin
    #200000;
    n_errors++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    op(0, 1, 0, LACID_OFF_LATCHED, 8'h00, LACID_LATCHED_RST);
    op(0, 1, 0, LACID_OFF_STATUS, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      op(1, 0, 0, ids[i], lacid_byte_t'($random(seed)), 8'h00);
      op(0, 1, 0, ids[i], 8'h00, codes[i]);
    end
    // Two settings that each hold all four codes first, then random settings
    for (int i = 0; i < 10; i++)
    begin
      p = (i == 0) ? 8'h1b : (i == 1) ? 8'he4 : lacid_byte_t'($random(seed));
      prog_cfg <= p;
      op(0, 0, 1, 8'h00, 8'h00, 8'h00);
      op(0, 1, 0, LACID_OFF_LATCHED, 8'h00, act_m);
      chk(active_cfg, cln(p));
      lat_m = act_m;
      act_m = cln(p);
      op(0, 1, 0, LACID_OFF_STATUS, 8'h00, 8'h02);
      chk({7'h00, latched_valid}, 8'h00);
      if (i == 3)
      begin
        idle(SC - 4);
        op(0, 0, 1, 8'h00, 8'h00, 8'h00);
        lat_m = act_m;
        idle(4);
        op(0, 1, 0, LACID_OFF_STATUS, 8'h00, 8'h02);
      end
      idle(SC);
      op(0, 1, 0, LACID_OFF_STATUS, 8'h00, 8'h01);
      chk({7'h00, latched_valid}, 8'h01);
      op(0, 1, 0, LACID_OFF_LATCHED, 8'h00, lat_m);
      p = lacid_byte_t'($random(seed));
      op(1, 0, 0, LACID_OFF_LATCHED, p, 8'h00);
      lat_m = cln(p);
      op(0, 1, 0, LACID_OFF_LATCHED, 8'h00, cln(p));
    end
    // Enable low: refresh and write must both be dropped
    ce <= 1'b0;
    prog_cfg <= 8'h66;
    op(0, 0, 1, 8'h00, 8'h00, 8'h00);
    op(1, 0, 0, LACID_OFF_LATCHED, 8'h99, 8'h00);
    ce <= 1'b1;
    op(0, 1, 0, LACID_OFF_LATCHED, 8'h00, lat_m);
    chk(active_cfg, act_m);
    op(0, 1, 0, LACID_OFF_STATUS, 8'h00, 8'h01);
    chk({7'h00, latched_valid}, 8'h01);
    // Reset in mid-run clears fields, flag and timer
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    op(0, 1, 0, LACID_OFF_LATCHED, 8'h00, LACID_LATCHED_RST);
    chk(active_cfg, LACID_ACTIVE_RST);
    op(0, 1, 0, LACID_OFF_STATUS, 8'h00, 8'h00);
    chk({7'h00, latched_valid}, 8'h00);
    idle(3);
    end_sim;
  end
endmodule
